// ===== rtl/rmd_fifo.v
`timescale 1ns/100ps
// synchronous fifo, read data registered
module rmd_fifo #(
   parameter WIDTH = 9,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire sys_clk,
   input wire rst,
   input wire inValid,
   output wire inReady,
   input wire [WIDTH-1:0] inData,
   output wire outValid,
   input wire outReady,
   output reg [WIDTH-1:0] outData_q
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0] wrPtr_q;
   reg [AW:0] rdPtr_q;
   reg [AW:0] count_q;
   wire doWr = inValid & inReady;
   wire doRd = outValid & outReady;
   wire [AW:0] rdPtrD = doRd ? rdPtr_q + 1'b1 : rdPtr_q;
   wire [AW-1:0] rdIdx = rdPtrD[AW-1:0];

   assign inReady = (count_q != DEPTH[AW:0]);
   assign outValid = (count_q != {(AW+1){1'b0}});

   // pointers wrap at depth; count gives honest full and empty
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wrPtr_q <= {(AW+1){1'b0}};
         rdPtr_q <= {(AW+1){1'b0}};
         count_q <= {(AW+1){1'b0}};
      end else begin
         if (doWr)
            wrPtr_q <= (wrPtr_q[AW-1:0] == DEPTH[AW-1:0] - 1'b1) ?
               {(AW+1){1'b0}} : wrPtr_q + 1'b1;
         if (doRd)
            rdPtr_q <= (rdPtr_q[AW-1:0] == DEPTH[AW-1:0] - 1'b1) ?
               {(AW+1){1'b0}} : rdPtr_q + 1'b1;
         count_q <= count_q + {{AW{1'b0}}, doWr} - {{AW{1'b0}}, doRd};
      end
   end

   // head word lands in a register; bypass a write into the head slot
   always @(posedge sys_clk) begin
      if (doWr)
         mem[wrPtr_q[AW-1:0]] <= inData;
      if (doRd && rdPtr_q[AW-1:0] == DEPTH[AW-1:0] - 1'b1)
         outData_q <= (doWr && wrPtr_q[AW-1:0] == {AW{1'b0}}) ?
            inData : mem[{AW{1'b0}}];
      else if (doWr && wrPtr_q[AW-1:0] == rdIdx)
         outData_q <= inData;
      else
         outData_q <= mem[rdIdx];
   end
endmodule

// ===== rtl/rmd_map.vh
`ifndef RMD_MAP_VH
`define RMD_MAP_VH
// register byte offsets
`define RMD_OFS_DATA 8'h00
`define RMD_OFS_DIV 8'h04
`define RMD_OFS_STAT 8'h08
`define RMD_OFS_MISC 8'h0c
`define RMD_OFS_CTRL 8'h4c
`define RMD_OFS_ADR 8'h50
`define RMD_OFS_DLY 8'h54
// multidrop control fields
`define RMD_NMM 0
`define RMD_RXDIS 1
`define RMD_AAD 2
`define RMD_SEL 3
`define RMD_DCTRL 4
`define RMD_OINV 5
`define RMD_CTRL_W 6
// misc control fields
`define RMD_M_RTS 0
`define RMD_M_DTR 1
`define RMD_M_LOOP 2
// status fields
`define RMD_S_RXAV 0
`define RMD_S_TEMT 1
`define RMD_S_OVR 2
`define RMD_S_FERR 3
`define RMD_S_DIR 4
// reset values
`define RMD_CTRL_RST 6'h00
`define RMD_ADR_RST 8'h00
`define RMD_DLY_RST 8'h00
`define RMD_DIV_RST 16'h0001
`define RMD_MISC_RST 3'h0
// serial framing: start, 8 data, ninth bit, stop
`define RMD_OVS_LAST 4'hf
`define RMD_OVS_MID 4'h7
`define RMD_BIT_NINTH 4'h9
`define RMD_BIT_STOP 4'ha
`endif

// ===== rtl/rmd_rx.v
`timescale 1ns/100ps
`include "rmd_map.vh"
// receive shift register: start, 8 data, ninth bit, stop
module rmd_rx (
   input wire sys_clk,
   input wire rst,
   input wire rxIn,
   input wire tick,
   output reg charValid_q,
   output reg [8:0] charData_q,
   output reg frameErr_q
);
   reg busy_q;
   reg [3:0] ovs_q;
   reg [3:0] bitIdx_q;

   // mid-bit sampling on the 16x enable
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         busy_q <= 1'b0;
         ovs_q <= 4'h0;
         bitIdx_q <= 4'h0;
         charValid_q <= 1'b0;
         charData_q <= 9'h000;
         frameErr_q <= 1'b0;
      end else begin
         charValid_q <= 1'b0;
         if (tick) begin
            if (!busy_q) begin
               if (!rxIn) begin
                  busy_q <= 1'b1;
                  ovs_q <= 4'h0;
                  bitIdx_q <= 4'h0;
               end
            end else begin
               ovs_q <= ovs_q + 4'h1;
               if (ovs_q == `RMD_OVS_MID) begin
                  bitIdx_q <= bitIdx_q + 4'h1;
                  if (bitIdx_q == 4'h0) begin
                     // glitch, not a start bit
                     if (rxIn)
                        busy_q <= 1'b0;
                  end else if (bitIdx_q == `RMD_BIT_STOP) begin
                     charValid_q <= 1'b1;
                     frameErr_q <= ~rxIn;
                     busy_q <= 1'b0;
                  end else begin
                     charData_q <= {rxIn, charData_q[8:1]};
                  end
               end
            end
         end
      end
   end
endmodule

// ===== rtl/rmd_uart.v
`timescale 1ns/100ps
`include "rmd_map.vh"
module rmd_uart #(
   parameter FIFO_DEPTH = 8,
   parameter FIFO_AW = 3
) (
   input wire sys_clk,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire rxdPin,
   output reg txdPin_q,
   output reg rtsPinN_q,
   output reg dtrPinN_q,
   output reg rxReadyPulse_q,
   output reg addrParityPulse_q,
   output reg txEmptyPulse_q
);
   localparam TX_IDLE = 2'h0;
   localparam TX_SHIFT = 2'h1;
   localparam TX_HOLD = 2'h2;

   reg [`RMD_CTRL_W-1:0] ctrl_q;
   reg [7:0] adrMatch_q;
   reg [7:0] dly_q;
   reg [15:0] div_q;
   reg [2:0] misc_q;
   reg overrun_q;
   reg frameErrSticky_q;
   reg [1:0] rxSync_q;
   reg [15:0] baudCnt_q;
   reg tick_q;
   reg [1:0] txState_q;
   reg [10:0] txShift_q;
   reg [3:0] txOvs_q;
   reg [3:0] txBit_q;
   reg [7:0] dlyCnt_q;
   reg dirActive_q;
   reg pushRx;
   reg hwSetDis;
   reg hwClrDis;

   wire [8:0] rxChar;
   wire rxValid;
   wire rxFerr;
   wire rxFifoInReady;
   wire rxFifoValid;
   wire [8:0] rxFifoData;
   wire txFifoReady;
   wire txFifoValid;
   wire [8:0] txFifoData;
   wire txPop;

   wire setup = psel & ~penable;
   wire access = psel & penable;
   wire wrAcc = access & pwrite & pready;
   wire rdSetup = setup & ~pwrite; // read side effects land with the capture
   wire txWr = wrAcc & (paddr == `RMD_OFS_DATA);
   wire loopback = misc_q[`RMD_M_LOOP];
   wire nmmOn = ctrl_q[`RMD_NMM];
   wire aadOn = ctrl_q[`RMD_NMM] & ctrl_q[`RMD_AAD];
   wire rxDis = ctrl_q[`RMD_RXDIS];
   wire isAddr = rxChar[8] & nmmOn;
   wire adrHit = (rxChar[7:0] == adrMatch_q);
   wire txSerial = (txState_q == TX_SHIFT) ? txShift_q[0] : 1'b1;
   wire rxLine = loopback ? txSerial : rxSync_q[1]; // loop inside the pin
   wire rxPop = rdSetup & (paddr == `RMD_OFS_DATA) & rxFifoValid;
   wire txBusy = txFifoValid | (txState_q != TX_IDLE);

   // writes to the transmit fifo stall the bus while it is full
   assign pready = ~(access & pwrite & (paddr == `RMD_OFS_DATA) &
      ~txFifoReady);
   assign pslverr = 1'b0;

   // two flops before the serial input is looked at
   always @(posedge sys_clk or posedge rst) begin
      if (rst)
         rxSync_q <= 2'b11;
      else
         rxSync_q <= {rxSync_q[0], rxdPin};
   end

   // divisor of zero behaves as one so the enable never stops
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         baudCnt_q <= 16'h0000;
         tick_q <= 1'b0;
      end else if (baudCnt_q + 16'h0001 >= div_q) begin
         baudCnt_q <= 16'h0000;
         tick_q <= 1'b1;
      end else begin
         baudCnt_q <= baudCnt_q + 16'h0001;
         tick_q <= 1'b0;
      end
   end

   rmd_rx u_rx (
      .sys_clk(sys_clk),
      .rst(rst),
      .rxIn(rxLine),
      .tick(tick_q),
      .charValid_q(rxValid),
      .charData_q(rxChar),
      .frameErr_q(rxFerr)
   );

   // address filtering decides whether a received character is stored
   always @* begin
      pushRx = 1'b0;
      hwSetDis = 1'b0;
      hwClrDis = 1'b0;
      if (rxValid) begin
         if (aadOn) begin
            if (isAddr && adrHit) begin
               pushRx = 1'b1;
               hwClrDis = 1'b1;
            end else if (isAddr) begin
               hwSetDis = ~rxDis;
            end else begin
               pushRx = ~rxDis;
            end
         end else if (nmmOn && rxDis) begin
            pushRx = isAddr;
         end else begin
            pushRx = 1'b1;
         end
      end
   end

   rmd_fifo #(
      .WIDTH(9),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_receive_fifo (
      .sys_clk(sys_clk),
      .rst(rst),
      .inValid(pushRx),
      .inReady(rxFifoInReady),
      .inData(rxChar),
      .outValid(rxFifoValid),
      .outReady(rxPop),
      .outData_q(rxFifoData)
   );

   rmd_fifo #(
      .WIDTH(9),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_transmit_fifo (
      .sys_clk(sys_clk),
      .rst(rst),
      .inValid(txWr),
      .inReady(txFifoReady),
      .inData(pwdata[8:0]),
      .outValid(txFifoValid),
      .outReady(txPop),
      .outData_q(txFifoData)
   );

   // one-cycle causes toward the interrupt logic
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rxReadyPulse_q <= 1'b0;
         addrParityPulse_q <= 1'b0;
         txEmptyPulse_q <= 1'b0;
      end else begin
         rxReadyPulse_q <= pushRx & rxFifoInReady;
         addrParityPulse_q <= pushRx & isAddr & ~aadOn;
         txEmptyPulse_q <= txPop & ~txWr;
      end
   end

   // register writes; hardware receiver-disable updates win over software
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= `RMD_CTRL_RST;
         adrMatch_q <= `RMD_ADR_RST;
         dly_q <= `RMD_DLY_RST;
         div_q <= `RMD_DIV_RST;
         misc_q <= `RMD_MISC_RST;
      end else begin
         if (wrAcc) begin
            case (paddr)
               `RMD_OFS_CTRL: ctrl_q <= pwdata[`RMD_CTRL_W-1:0];
               `RMD_OFS_ADR: adrMatch_q <= pwdata[7:0];
               `RMD_OFS_DLY: dly_q <= pwdata[7:0];
               `RMD_OFS_DIV: div_q <= pwdata[15:0];
               `RMD_OFS_MISC: misc_q <= pwdata[2:0];
               default: ;
            endcase
         end
         if (hwClrDis)
            ctrl_q[`RMD_RXDIS] <= 1'b0;
         else if (hwSetDis)
            ctrl_q[`RMD_RXDIS] <= 1'b1;
      end
   end

   // sticky errors clear at the status capture edge; a new event wins
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         overrun_q <= 1'b0;
         frameErrSticky_q <= 1'b0;
      end else begin
         if (pushRx && !rxFifoInReady)
            overrun_q <= 1'b1;
         else if (rdSetup && paddr == `RMD_OFS_STAT)
            overrun_q <= 1'b0;
         if (rxValid && rxFerr)
            frameErrSticky_q <= 1'b1;
         else if (rdSetup && paddr == `RMD_OFS_STAT)
            frameErrSticky_q <= 1'b0;
      end
   end

   // read data captured in the setup phase; unmapped reads give zero
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         prdata <= 32'h00000000;
      end else if (setup) begin
         prdata <= 32'h00000000;
         case (paddr)
            `RMD_OFS_DATA: prdata[8:0] <= rxFifoData;
            `RMD_OFS_DIV: prdata[15:0] <= div_q;
            `RMD_OFS_STAT: begin
               prdata[`RMD_S_RXAV] <= rxFifoValid;
               prdata[`RMD_S_TEMT] <= ~txBusy;
               prdata[`RMD_S_OVR] <= overrun_q;
               prdata[`RMD_S_FERR] <= frameErrSticky_q;
               prdata[`RMD_S_DIR] <= dirActive_q;
            end
            `RMD_OFS_MISC: prdata[2:0] <= misc_q;
            `RMD_OFS_CTRL: prdata[`RMD_CTRL_W-1:0] <= ctrl_q;
            `RMD_OFS_ADR: prdata[7:0] <= adrMatch_q;
            `RMD_OFS_DLY: prdata[7:0] <= dly_q;
            default: ;
         endcase
      end
   end

   assign txPop = txFifoValid & (txState_q == TX_IDLE ||
      (txState_q == TX_HOLD));

   // transmit shifter; hold state counts the turn-off delay in bit times
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         txState_q <= TX_IDLE;
         txShift_q <= 11'h7ff;
         txOvs_q <= 4'h0;
         txBit_q <= 4'h0;
         dlyCnt_q <= 8'h00;
      end else begin
         case (txState_q)
            TX_IDLE: begin
               if (txFifoValid) begin
                  txShift_q <= {1'b1, txFifoData, 1'b0};
                  txOvs_q <= 4'h0;
                  txBit_q <= 4'h0;
                  txState_q <= TX_SHIFT;
               end
            end
            TX_SHIFT: begin
               if (tick_q) begin
                  txOvs_q <= txOvs_q + 4'h1;
                  if (txOvs_q == `RMD_OVS_LAST) begin
                     txShift_q <= {1'b1, txShift_q[10:1]};
                     txBit_q <= txBit_q + 4'h1;
                     if (txBit_q == `RMD_BIT_STOP) begin
                        dlyCnt_q <= dly_q;
                        txState_q <= TX_HOLD;
                     end
                  end
               end
            end
            TX_HOLD: begin
               if (txFifoValid) begin
                  txShift_q <= {1'b1, txFifoData, 1'b0};
                  txOvs_q <= 4'h0;
                  txBit_q <= 4'h0;
                  txState_q <= TX_SHIFT;
               end else if (dlyCnt_q == 8'h00) begin
                  txState_q <= TX_IDLE;
               end else if (tick_q) begin
                  txOvs_q <= txOvs_q + 4'h1;
                  if (txOvs_q == `RMD_OVS_LAST)
                     dlyCnt_q <= dlyCnt_q - 8'h01;
               end
            end
            default: txState_q <= TX_IDLE;
         endcase
      end
   end

   // direction asserted from the transmit write until the delay expires
   always @(posedge sys_clk or posedge rst) begin
      if (rst)
         dirActive_q <= 1'b0;
      else if (txWr)
         dirActive_q <= 1'b1;
      else if (txState_q == TX_HOLD && dlyCnt_q == 8'h00 && !txFifoValid)
         dirActive_q <= 1'b0;
   end

   // pins: loopback keeps them quiet, otherwise auto direction wins
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         txdPin_q <= 1'b1;
         rtsPinN_q <= 1'b1;
         dtrPinN_q <= 1'b1;
      end else if (loopback) begin
         txdPin_q <= 1'b1;
         rtsPinN_q <= 1'b1;
         dtrPinN_q <= 1'b1;
      end else begin
         txdPin_q <= txSerial;
         rtsPinN_q <= ~misc_q[`RMD_M_RTS];
         dtrPinN_q <= ~misc_q[`RMD_M_DTR];
         if (ctrl_q[`RMD_DCTRL]) begin
            if (ctrl_q[`RMD_SEL])
               dtrPinN_q <= dirActive_q ~^ ctrl_q[`RMD_OINV];
            else
               rtsPinN_q <= dirActive_q ~^ ctrl_q[`RMD_OINV];
         end
      end
   end
endmodule

// ===== tb/rmd_line_master.sv
`timescale 1ns/100ps
// far-end bus master: one 11-bit frame per request
module rmd_line_master (
   input wire sys_clk,
   input wire go,
   input wire [8:0] word,
   input wire [15:0] bitClks,
   output logic rxd,
   output logic busy
);
   logic [10:0] frame;
   // biased line idles at mark
   initial begin
      rxd = 1'b1;
      busy = 1'b0;
   end
   // start, 8 data lsb first, ninth bit, stop
   always begin
      @(posedge sys_clk iff go);
      busy = 1'b1;
      frame = {1'b1, word, 1'b0};
      @(negedge sys_clk);
      for (int i = 0; i < 11; i++) begin
         rxd = frame[i];
         repeat (bitClks) @(negedge sys_clk);
      end
      busy = 1'b0;
   end
endmodule

// ===== tb/rmd_uart_checker.sv
`timescale 1ns/100ps
`include "rmd_map.vh"
// shadows config writes from the bus to judge the pins
module rmd_uart_checker (
   input wire sys_clk,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   input wire pready,
   input wire txdPin_q,
   input wire rtsPinN_q,
   input wire dtrPinN_q,
   input wire rxReadyPulse_q,
   input wire addrParityPulse_q,
   input wire txEmptyPulse_q
);
   reg [5:0] ctl_q;
   reg [2:0] misc_q;
   reg [1:0] quiet_q;
   wire wr = psel && penable && pwrite && pready;
   wire cfg = paddr == `RMD_OFS_CTRL || paddr == `RMD_OFS_MISC;
   wire autoOn = quiet_q == 2'h3 && ctl_q[4] && !misc_q[2];
   // quiet_q waits out the pin register lag after a config write
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctl_q <= 6'h00;
         misc_q <= 3'h0;
         quiet_q <= 2'h0;
      end else begin
         if (wr && paddr == `RMD_OFS_CTRL)
            ctl_q <= pwdata[5:0];
         if (wr && paddr == `RMD_OFS_MISC)
            misc_q <= pwdata[2:0];
         if (wr && cfg)
            quiet_q <= 2'h0;
         else if (quiet_q != 2'h3)
            quiet_q <= quiet_q + 2'h1;
      end
   end
   default clocking dc @(posedge sys_clk); endclocking
   default disable iff (rst);
   AST_RDY_ONE: assert property (rxReadyPulse_q |=> !rxReadyPulse_q)
      else $error("ready pulse too wide");
   AST_PAR_ONE: assert property (
      addrParityPulse_q |=> !addrParityPulse_q)
      else $error("parity pulse too wide");
   AST_TXE_ONE: assert property (txEmptyPulse_q |=> !txEmptyPulse_q)
      else $error("empty pulse too wide");
   AST_PAR_MODE: assert property (addrParityPulse_q |->
      rxReadyPulse_q && ctl_q[0] && !ctl_q[2])
      else $error("parity pulse outside normal multidrop");
   AST_WAIT_TX: assert property (
      !pready |-> psel && pwrite && paddr == `RMD_OFS_DATA)
      else $error("wait state on wrong access");
   AST_START_BIT: assert property ($fell(txdPin_q) |-> !txdPin_q [*8])
      else $error("start bit too short");
   AST_DIR_ON: assert property (
      autoOn && !txdPin_q |->
      (ctl_q[3] ? dtrPinN_q : rtsPinN_q) == ctl_q[5])
      else $error("direction pin inactive in frame");
   AST_DIR_OTHER: assert property (autoOn |->
      (ctl_q[3] ? rtsPinN_q : dtrPinN_q) != misc_q[ctl_q[3] ? 0 : 1])
      else $error("unselected pin disturbed");
   cover property (autoOn && !txdPin_q);
   cover property (rxReadyPulse_q);
   cover property (addrParityPulse_q);
   cover property (!pready);
endmodule

bind rmd_uart rmd_uart_checker chk_u (.sys_clk(sys_clk), .rst(rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pready(pready), .txdPin_q(txdPin_q),
   .rtsPinN_q(rtsPinN_q), .dtrPinN_q(dtrPinN_q),
   .rxReadyPulse_q(rxReadyPulse_q),
   .addrParityPulse_q(addrParityPulse_q),
   .txEmptyPulse_q(txEmptyPulse_q));

// ===== tb/uart_rs485_multidrop_bench.sv
`timescale 1ns/100ps
`include "rmd_map.vh"
module uart_rs485_multidrop_bench;
   typedef struct packed {
      logic [5:0] c;
      logic [8:0] w;
      logic [2:0] f;
   } rmd_row_t;
   logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, rxdPin;
   logic txdPin_q, rtsPinN_q, dtrPinN_q, lineGo, lineBusy;
   logic rxReadyPulse_q, addrParityPulse_q, txEmptyPulse_q;
   logic [7:0] paddr;
   logic [8:0] lineWord;
   logic [31:0] pwdata, prdata, q;
   int failures, checked, rdyCnt, parCnt, teCnt, w, n;
   rmd_row_t r;
   // ctrl, word, {stored, parity pulse, rxdis after}
   rmd_row_t rows [11] = '{
      '{6'h01, 9'h055, 3'h4},
      '{6'h01, 9'h1a5, 3'h6},
      '{6'h03, 9'h033, 3'h1},
      '{6'h03, 9'h17e, 3'h7},
      '{6'h07, 9'h042, 3'h1},
      '{6'h07, 9'h1c2, 3'h1},
      '{6'h07, 9'h142, 3'h4},
      '{6'h05, 9'h099, 3'h4},
      '{6'h05, 9'h143, 3'h1},
      '{6'h06, 9'h0c3, 3'h5},
      '{6'h06, 9'h1c3, 3'h5}};
   rmd_uart dut_u (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .rxdPin, .txdPin_q,
      .rtsPinN_q, .dtrPinN_q, .rxReadyPulse_q, .addrParityPulse_q,
      .txEmptyPulse_q);
   rmd_line_master line_u (.sys_clk, .go(lineGo), .word(lineWord),
      .bitClks(16'h0010), .rxd(rxdPin), .busy(lineBusy));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // count receive, parity and transmit-empty pulses between checks
   always @(posedge sys_clk) begin
      if (rxReadyPulse_q === 1'b1)
         rdyCnt++;
      if (addrParityPulse_q === 1'b1)
         parCnt++;
      if (txEmptyPulse_q === 1'b1)
         teCnt++;
   end
   task end_sim;
      if (failures == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task check(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // request held until pready is seen high at a rising edge
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(negedge sys_clk);
      psel = 1'b1;
      pwrite = wr;
      paddr = a;
      pwdata = d;
      @(negedge sys_clk);
      penable = 1'b1;
      w = 0;
      @(posedge sys_clk);
      while (pready !== 1'b1 && w < 400) begin
         w++;
         @(posedge sys_clk);
      end
      q = prdata;
      if (w == 400)
         failures++;
      @(negedge sys_clk);
      psel = 1'b0;
      penable = 1'b0;
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] e, m, input string nm);
      apb(1'b0, a, 32'h0);
      check(nm, e, q & m);
      check("slverr", 32'h0, pslverr);
   endtask
   task send(input logic [8:0] wd);
      @(negedge sys_clk);
      lineWord = wd;
      lineGo = 1'b1;
      @(negedge sys_clk);
      lineGo = 0;
      n = 0;
      while (lineBusy !== 1'b0 && n < 400) begin
         n++;
         @(negedge sys_clk);
      end
      repeat (8) @(negedge sys_clk);
   endtask
   // one frame with direction control; sampled mid-bit
   task txrun(input logic [5:0] c, input logic [7:0] dl, input logic [2:0] ms,
         input logic [15:0] dv, input logic [8:0] wd);
      logic [10:0] f;
      int lo;
      f = {1'b1, wd, 1'b0};
      lo = dl == 0 ? 0 : 16 * dl * dv - 8 * dv;
      apb(1'b1, `RMD_OFS_DIV, dv);
      apb(1'b1, `RMD_OFS_DLY, dl);
      apb(1'b1, `RMD_OFS_MISC, ms);
      apb(1'b1, `RMD_OFS_CTRL, c);
      apb(1'b1, `RMD_OFS_DATA, wd);
      n = 0;
      while (txdPin_q !== 1'b0 && n < 40) begin
         n++;
         @(negedge sys_clk);
      end
      repeat (8 * dv) @(negedge sys_clk);
      check("dirOn", c[5], c[3] ? dtrPinN_q : rtsPinN_q);
      check("otherPin", 1'b1, c[3] ? rtsPinN_q : dtrPinN_q);
      for (int i = 0; i < 11; i++) begin
         check("txBit", f[i], txdPin_q);
         repeat (16 * dv) @(negedge sys_clk);
      end
      n = 0;
      while ((c[3] ? dtrPinN_q : rtsPinN_q) === c[5] && n < 4200) begin
         n++;
         @(negedge sys_clk);
      end
      check("dirOff", 1'b1, n >= lo && n <= 16 * dl * dv + 4);
   endtask
   initial begin
      repeat (40000) @(posedge sys_clk);
      failures++;
      end_sim;
   end
   initial begin
      {psel, penable, pwrite, lineGo} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      lineWord = 9'h000;
      {failures, checked, rdyCnt, parCnt} = 128'h0;
      rst = 1'b1;
      repeat (12) @(negedge sys_clk);
      rst = 1'b0;
      // reset values, then a hole that ignores writes
      rdc(`RMD_OFS_CTRL, 32'h0, 32'h3f, "ctrl");
      rdc(`RMD_OFS_DLY, 32'h0, 32'hff, "delay");
      rdc(`RMD_OFS_DIV, 32'h1, 32'hffff, "div");
      rdc(`RMD_OFS_STAT, 32'h2, 32'h1f, "status");
      apb(1'b1, 8'h40, 32'hffffffff);
      rdc(8'h40, 32'h0, 32'hffffffff, "hole");
      rdc(`RMD_OFS_ADR, 32'h0, 32'hff, "match");
      apb(1'b1, `RMD_OFS_ADR, 32'h42);
      rdc(`RMD_OFS_ADR, 32'h42, 32'hff, "match");
      foreach (rows[i]) begin
         r = rows[i];
         apb(1'b1, `RMD_OFS_CTRL, r.c);
         rdyCnt = 0;
         parCnt = 0;
         send(r.w);
         check("stored", r.f[2], rdyCnt);
         check("parity", r.f[1], parCnt);
         rdc(`RMD_OFS_CTRL, {r.f[0], 1'b0}, 32'h2, "rxdis");
         if (r.f[2])
            rdc(`RMD_OFS_DATA, r.w, 32'h1ff, "rxWord");
      end
      // rx fifo overflows on the ninth char, then drains
      apb(1'b1, `RMD_OFS_CTRL, 32'h0);
      for (int i = 0; i < 9; i++)
         send(9'h0a0 + i);
      rdc(`RMD_OFS_STAT, 32'h5, 32'h5, "overrun");
      for (int i = 0; i < 8; i++)
         rdc(`RMD_OFS_DATA, 9'h0a0 + i, 32'h1ff, "drain");
      rdc(`RMD_OFS_STAT, 32'h0, 32'h5, "rxEmpty");
      // tx: eight slots plus the shifter, the tenth write waits
      teCnt = 0;
      for (int i = 0; i < 10; i++) begin
         apb(1'b1, `RMD_OFS_DATA, i);
         check("txWait", i == 9, w > 0);
      end
      q = 32'h0;
      n = 0;
      while (q[1] !== 1'b1 && n < 1000) begin
         n++;
         apb(1'b0, `RMD_OFS_STAT, 32'h0);
      end
      check("txDone", 1'b1, q[1]);
      check("txPops", 32'ha, teCnt);
      txrun(6'h10, 8'h00, 3'h1, 16'h0001, 9'h0a5);
      txrun(6'h38, 8'h02, 3'h0, 16'h0002, 9'h15a);
      txrun(6'h30, 8'hff, 3'h0, 16'h0001, 9'h000);
      // loopback: pins stay quiet, the frame comes back on the inside
      apb(1'b1, `RMD_OFS_MISC, 32'h4);
      apb(1'b1, `RMD_OFS_CTRL, 32'h10);
      apb(1'b1, `RMD_OFS_DATA, 32'h1b6);
      repeat (20) @(negedge sys_clk);
      check("loopRts", 1'b1, rtsPinN_q);
      check("loopTxd", 1'b1, txdPin_q);
      repeat (200) @(negedge sys_clk);
      rdc(`RMD_OFS_DATA, 32'h1b6, 32'h1ff, "loopWord");
      end_sim;
   end
endmodule
